//--- hdl/vsc_scan_controller.sv
// Display scan controller: register file, display memory fetch and pin drive.
// Assumes a data memory that answers a DMA read one cycle after it is asked.
//
// Overview of operation
// RULE_01 - DMA fetch drives segments and digits autonomously
// RULE_02 - Up to 24 segments, 16 digits
// RULE_03 - Unused outputs serve as static ports
// RULE_04 - Segment pins shared with output port bits
// RULE_05 - Key scan interrupt at key scan slot
// RULE_06 - Key scan buffers drive segments then
// RULE_07 - Period equals slot time times N+2
// RULE_08 - Digit pulse width has eight levels
// RULE_09 - Works only on fast main clock
// RULE_10 - Host clears enable before standby
// RULE_11 - Mode register 4 bits, resets zero
// RULE_12 - Bits 2:0 pick 9 to 16 segments
// RULE_13 - Dynamic upper group adds eight segments
// RULE_14 - Mode bit 3 enables display
// RULE_15 - Display memory sits at 1A0H-1FFH
// RULE_16 - Digit count 8-15 only, reset 8
// RULE_17 - Dimmer bit 0 picks slot length
// RULE_18 - Dimmer bits 3:1 set cut width
// RULE_19 - Digits ascend, one per slot, then key scan
`timescale 1ns/1ps
`include "vsc_params.svh"
module vsc_scan_controller #(
  parameter int SEG_N = 24,
  parameter int DIG_N = 16
) (
  input wire logic clk, // main clock, 10 MHz
  input wire logic rst, // sync reset, high
  input wire logic [11:0] cpu_addr, // data memory address
  input wire logic cpu_wr, // write strobe
  input wire logic cpu_rd, // read strobe
  input wire logic [7:0] cpu_wdata, // write data
  output logic [7:0] cpu_rdata, // read data, next cycle
  output logic [8:0] dma_addr, // display memory address
  output logic dma_rd, // display memory read
  input wire logic [3:0] dma_data, // read data, one cycle later
  input wire logic [23:0] port_latch, // general output port bits
  output logic [23:0] segment_outputs, // segment pins
  output logic [15:0] digit_outputs, // digit pins
  output logic key_scan_irq // key scan request pulse
);
  logic [3:0] mode_r, mode_nxt, dimmer_setting_r, dimmer_setting_nxt, digit_count_setting_r, digit_count_setting_nxt, lower_segment_static_select_r, lower_segment_static_select_nxt;
  logic [1:0] upper_segment_static_select_r, upper_segment_static_select_nxt;
  logic [7:0] rdata_r, rdata_nxt;
  vsc_pkg::vsc_fetch_t fst_r, fst_nxt;
  logic [4:0] slot_r, slot_nxt, last_slot, nslot;
  logic [2:0] idx_r, idx_nxt, cap_idx_r, cap_idx_nxt, ridx_r, ridx_nxt;
  logic cap_r, cap_nxt, kscan_r, kscan_nxt, irq_r, irq_nxt, rd_r, rd_nxt;
  logic [8:0] addr_r, addr_nxt;
  logic [23:0] shadow_r, shadow_nxt, cur_r, cur_nxt, seg_r, seg_nxt;
  logic [15:0] dig_r, dig_nxt, lmask;
  logic en, static_a, static_b, slot_end, digit_on;

  initial begin
    if (SEG_N != 24 || DIG_N != 16) $error("vsc_scan_controller: only 24 segments and 16 digits");
  end

  // Lower segment enable mask for a segment count code
  function automatic logic [15:0] low_mask(input logic [2:0] code);
    logic [4:0] cnt;
    cnt = `VSC_SEG_LOW_BASE + {2'b00, code};
    for (int i = 0; i < 16; i++) begin
      low_mask[i] = (5'(i) < cnt);
    end
  endfunction

  // Display memory nibble for fetch step i of a slot
  function automatic logic [8:0] fetch_addr(input logic [4:0] s, input logic ks, input logic [2:0] i);
    if (ks) begin
      case (i)
        3'h0: fetch_addr = `VSC_DMEM_KS0;
        3'h1: fetch_addr = `VSC_DMEM_KS0 + 9'h001;
        3'h2: fetch_addr = `VSC_DMEM_KS1;
        3'h3: fetch_addr = `VSC_DMEM_KS1 + 9'h001;
        3'h4: fetch_addr = `VSC_DMEM_KS2;
        default: fetch_addr = `VSC_DMEM_KS2 + 9'h001;
      endcase
    end else if (i < 3'h4) begin
      fetch_addr = `VSC_DMEM_LOW + {3'b000, s[3:0], 2'b00} + {6'b000000, i};
    end else begin
      fetch_addr = `VSC_DMEM_UP + {4'b0000, s[3:0], 1'b0} + {6'b000000, i - 3'h4};
    end
  endfunction

  // Register file
  always_comb begin
    mode_nxt = mode_r;
    dimmer_setting_nxt = dimmer_setting_r;
    digit_count_setting_nxt = digit_count_setting_r;
    lower_segment_static_select_nxt = lower_segment_static_select_r;
    upper_segment_static_select_nxt = upper_segment_static_select_r;
    rdata_nxt = rdata_r;
    if (cpu_wr) begin
      case (cpu_addr)
        `VSC_ADDR_MODE: mode_nxt = cpu_wdata[3:0]; // RULE_11
        `VSC_ADDR_DIMMER_SETTING: dimmer_setting_nxt = cpu_wdata[3:0];
        `VSC_ADDR_DIGIT_COUNT_SETTING: if (cpu_wdata[`VSC_DIGIT_COUNT_SETTING_MIN_BIT]) digit_count_setting_nxt = cpu_wdata[3:0]; // RULE_16
        `VSC_ADDR_LOWER_SEGMENT_STATIC_SELECT: lower_segment_static_select_nxt = cpu_wdata[3:0];
        `VSC_ADDR_UPPER_SEGMENT_STATIC_SELECT: upper_segment_static_select_nxt = cpu_wdata[5:4];
        default: ;
      endcase
    end
    if (cpu_rd) begin
      case (cpu_addr)
        `VSC_ADDR_MODE: rdata_nxt = {4'h0, mode_r};
        `VSC_ADDR_DIMMER_SETTING: rdata_nxt = {4'h0, dimmer_setting_r};
        `VSC_ADDR_DIGIT_COUNT_SETTING: rdata_nxt = {4'h0, digit_count_setting_r};
        `VSC_ADDR_LOWER_SEGMENT_STATIC_SELECT: rdata_nxt = {4'h0, lower_segment_static_select_r};
        `VSC_ADDR_UPPER_SEGMENT_STATIC_SELECT: rdata_nxt = {2'b00, upper_segment_static_select_r, 4'h0};
        default: rdata_nxt = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      mode_r <= `VSC_MODE_RST; // RULE_11
      dimmer_setting_r <= `VSC_DIMMER_SETTING_RST;
      digit_count_setting_r <= `VSC_DIGIT_COUNT_SETTING_RST; // RULE_16
      lower_segment_static_select_r <= `VSC_STAT_RST;
      upper_segment_static_select_r <= 2'b00;
      rdata_r <= 8'h00;
    end else begin
      mode_r <= mode_nxt;
      dimmer_setting_r <= dimmer_setting_nxt;
      digit_count_setting_r <= digit_count_setting_nxt;
      lower_segment_static_select_r <= lower_segment_static_select_nxt;
      upper_segment_static_select_r <= upper_segment_static_select_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  assign en = mode_r[`VSC_MODE_EN_BIT]; // RULE_14
  assign static_a = &lower_segment_static_select_r; // RULE_03
  assign static_b = &upper_segment_static_select_r; // RULE_03
  assign lmask = low_mask(mode_r[2:0]); // RULE_12

  vsc_slot_timer #(.CNT_W(12)) u_timer (
    .clk(clk),
    .rst(rst),
    .run(en),
    .long_slot(dimmer_setting_r[0]),
    .cut_code(dimmer_setting_r[3:1]),
    .slot_end(slot_end),
    .digit_on(digit_on)
  );

  // Scan sequencing, DMA fetch and pin drive
  always_comb begin
    last_slot = {1'b0, digit_count_setting_r} + 5'h01; // RULE_07
    nslot = (slot_r >= last_slot) ? 5'h00 : slot_r + 5'h01; // RULE_19
    fst_nxt = fst_r;
    idx_nxt = idx_r;
    slot_nxt = slot_r;
    kscan_nxt = kscan_r;
    cur_nxt = cur_r;
    shadow_nxt = shadow_r;
    irq_nxt = 1'b0;
    rd_nxt = 1'b0;
    addr_nxt = addr_r;
    cap_nxt = rd_r;
    // Index travels with the read, then with the returned nibble
    ridx_nxt = ridx_r;
    cap_idx_nxt = ridx_r;
    if (cap_r) begin
      shadow_nxt[{cap_idx_r, 2'b00} +: 4] = dma_data; // RULE_01
    end
    case (fst_r)
      vsc_pkg::VSC_FS_IDLE: begin
        if (en) begin
          fst_nxt = vsc_pkg::VSC_FS_RUN;
          idx_nxt = 3'h0;
        end
      end
      vsc_pkg::VSC_FS_RUN: begin
        rd_nxt = 1'b1;
        addr_nxt = fetch_addr(nslot, nslot == last_slot, idx_r); // RULE_15 RULE_06
        ridx_nxt = idx_r;
        if (idx_r == `VSC_FETCH_LAST) fst_nxt = vsc_pkg::VSC_FS_DONE;
        else idx_nxt = idx_r + 3'h1;
      end
      vsc_pkg::VSC_FS_DONE: begin
        if (slot_end) begin
          slot_nxt = nslot; // RULE_19
          kscan_nxt = (nslot == last_slot);
          irq_nxt = (nslot == last_slot); // RULE_05
          cur_nxt = shadow_nxt;
          fst_nxt = vsc_pkg::VSC_FS_RUN;
          idx_nxt = 3'h0;
        end
      end
      default: fst_nxt = vsc_pkg::VSC_FS_IDLE;
    endcase
    if (!en) begin
      fst_nxt = vsc_pkg::VSC_FS_IDLE;
      slot_nxt = last_slot;
      kscan_nxt = 1'b0;
      cur_nxt = '0;
    end
    for (int i = 0; i < 16; i++) begin
      seg_nxt[i] = static_a ? port_latch[i] : (en && digit_on && cur_r[i] && (kscan_r || lmask[i])); // RULE_04 RULE_12
    end
    for (int i = 16; i < 24; i++) begin
      seg_nxt[i] = static_b ? port_latch[i] : (en && digit_on && cur_r[i]); // RULE_04 RULE_13
    end
    dig_nxt = 16'h0000;
    // The priming slot after enable sits at the key scan position and stays dark
    if (en && digit_on && !kscan_r && slot_r < last_slot) dig_nxt[slot_r[3:0]] = 1'b1; // RULE_08 RULE_19
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      fst_r <= vsc_pkg::VSC_FS_IDLE;
      idx_r <= 3'h0;
      slot_r <= {1'b0, `VSC_DIGIT_COUNT_SETTING_RST} + 5'h01;
      kscan_r <= 1'b0;
      cur_r <= 24'h000000;
      shadow_r <= 24'h000000;
      irq_r <= 1'b0;
      rd_r <= 1'b0;
      addr_r <= 9'h000;
      cap_r <= 1'b0;
      cap_idx_r <= 3'h0;
      ridx_r <= 3'h0;
      seg_r <= 24'h000000;
      dig_r <= 16'h0000;
    end else begin
      fst_r <= fst_nxt;
      idx_r <= idx_nxt;
      slot_r <= slot_nxt;
      kscan_r <= kscan_nxt;
      cur_r <= cur_nxt;
      shadow_r <= shadow_nxt;
      irq_r <= irq_nxt;
      rd_r <= rd_nxt;
      addr_r <= addr_nxt;
      cap_r <= cap_nxt;
      cap_idx_r <= cap_idx_nxt;
      ridx_r <= ridx_nxt;
      seg_r <= seg_nxt;
      dig_r <= dig_nxt;
    end
  end

  assign cpu_rdata = rdata_r;
  assign dma_addr = addr_r;
  assign dma_rd = rd_r;
  assign segment_outputs = seg_r; // RULE_02
  assign digit_outputs = dig_r;
  assign key_scan_irq = irq_r;

  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  logic [11:0] gap_r;
  logic armed_r;
  always_ff @(posedge clk) begin
    if (rst || !en) begin
      gap_r <= 12'h000;
      armed_r <= 1'b0;
    end else begin
      gap_r <= slot_end ? 12'h000 : gap_r + 12'h001;
      armed_r <= armed_r | slot_end;
    end
  end

  sequence s_fetch_start;
    fst_r == vsc_pkg::VSC_FS_DONE && slot_end;
  endsequence
  sequence s_burst;
    dma_rd [*6] ##1 !dma_rd;
  endsequence

  // A disable in mid-burst legally cuts the burst short
  AST_FETCH_BURST: assert property (disable iff (rst || !en) // RULE_01
    s_fetch_start |-> ##2 s_burst) else $error("fetch burst not six reads");
  AST_SLOT_LEN: assert property (slot_end && armed_r && $stable(dimmer_setting_r) |-> // RULE_17
    (gap_r == (dimmer_setting_r[0] ? 12'(`VSC_SLOT_CYC_LONG - 1) : 12'(`VSC_SLOT_CYC_SHORT - 1))))
    else $error("slot length wrong");
  AST_IRQ_KS: assert property (key_scan_irq |-> kscan_r && slot_r == {1'b0, digit_count_setting_r} + 5'h01) // RULE_05
    else $error("irq outside key scan slot");
  AST_KS_DARK: assert property (kscan_r |=> digit_outputs == 16'h0000) else $error("digit lit in key scan"); // RULE_06
  AST_ONE_DIGIT: assert property ($countones(digit_outputs) <= 1) else $error("two digits lit"); // RULE_19
  AST_DISABLED: assert property (!en ##1 !en |=> digit_outputs == 16'h0000 && !dma_rd) // RULE_14
    else $error("display active while disabled");
  AST_DIGIT_COUNT_SETTING_RANGE: assert property (digit_count_setting_r[`VSC_DIGIT_COUNT_SETTING_MIN_BIT]) else $error("digit count below 8"); // RULE_16
  AST_STATIC_PORT: assert property (static_a |=> segment_outputs[15:0] == $past(port_latch[15:0])) // RULE_04
    else $error("static segments not from port");
  AST_LOW_MASK: assert property (!static_a && !kscan_r |=> // RULE_12
    (segment_outputs[15:0] & ~$past(lmask)) == 16'h0000)
    else $error("segment beyond count lit");
endmodule // vsc_scan_controller

//--- hdl/vsc_params.svh
// Constants for the display scan controller: register addresses, reset values,
// display memory layout and slot timing. Included by the scan controller and the slot timer.
`ifndef VSC_PARAMS_SVH
`define VSC_PARAMS_SVH

// Register addresses on the 12-bit data memory port
`define VSC_ADDR_MODE 12'hF88
`define VSC_ADDR_DIMMER_SETTING 12'hF89
`define VSC_ADDR_DIGIT_COUNT_SETTING 12'hF8A
`define VSC_ADDR_UPPER_SEGMENT_STATIC_SELECT 12'hFD4
`define VSC_ADDR_LOWER_SEGMENT_STATIC_SELECT 12'hFD6

// Reset values
`define VSC_MODE_RST 4'h0
`define VSC_DIMMER_SETTING_RST 4'h0
`define VSC_DIGIT_COUNT_SETTING_RST 4'h8
`define VSC_STAT_RST 4'h0

// Field positions
`define VSC_MODE_EN_BIT 3
`define VSC_DIGIT_COUNT_SETTING_MIN_BIT 3
`define VSC_SEG_LOW_BASE 5'h09

// Display data memory layout (nibble addresses)
`define VSC_DMEM_LOW 9'h1C0
`define VSC_DMEM_UP 9'h1A0
`define VSC_DMEM_KS0 9'h1FC
`define VSC_DMEM_KS1 9'h1FE
`define VSC_DMEM_KS2 9'h1BE
`define VSC_FETCH_LAST 3'h5

// Slot time in main clock periods; the block clock is the main clock
`define VSC_SLOT_PER_SHORT 1024
`define VSC_SLOT_PER_LONG 2048
`define VSC_SLOT_CYC_SHORT (`VSC_SLOT_PER_SHORT * 1)
`define VSC_SLOT_CYC_LONG (`VSC_SLOT_PER_LONG * 1)

`endif

//--- hdl/vsc_pkg.sv
// Types shared by the display scan controller files.
// Assumes nothing beyond a SystemVerilog compiler.
package vsc_pkg;
  typedef enum logic [1:0] {
    VSC_FS_IDLE = 2'b00,
    VSC_FS_RUN = 2'b01,
    VSC_FS_DONE = 2'b10
  } vsc_fetch_t;
endpackage

//--- hdl/vsc_slot_timer.sv
// Slot timer: counts one display slot and the lit part of the digit pulse.
// Assumes clk is the main system clock and rst is synchronous.
`timescale 1ns/1ps
`include "vsc_params.svh"
module vsc_slot_timer #(
  parameter int CNT_W = 12
) (
  input wire logic clk, // main clock
  input wire logic rst, // sync reset, high
  input wire logic run, // display enabled
  input wire logic long_slot, // slot length select
  input wire logic [2:0] cut_code, // digit cut width code
  output logic slot_end, // last cycle of a slot
  output logic digit_on // digit pulse window
);
  logic [CNT_W-1:0] cnt_r, cnt_nxt, len, sixteenth, cut;
  logic on_r, on_nxt;

  initial begin
    if (CNT_W < 12) $error("vsc_slot_timer: CNT_W too small");
  end

  always_comb begin
    len = long_slot ? CNT_W'(`VSC_SLOT_CYC_LONG) : CNT_W'(`VSC_SLOT_CYC_SHORT); // RULE_17 RULE_09
    sixteenth = len >> 4;
    cut = (cut_code == 3'h0) ? sixteenth : CNT_W'(sixteenth * CNT_W'({cut_code, 1'b0})); // RULE_18
    slot_end = run && (cnt_r == len - CNT_W'(1));
    cnt_nxt = (!run || slot_end) ? '0 : cnt_r + CNT_W'(1);
    on_nxt = run && (cnt_nxt < len - cut); // RULE_08
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      cnt_r <= '0;
      on_r <= 1'b0;
    end else begin
      cnt_r <= cnt_nxt;
      on_r <= on_nxt;
    end
  end

  assign digit_on = on_r;

  AST_CUT_WINDOW: assert property (@(posedge clk) disable iff (rst) // RULE_18
    slot_end |-> !digit_on) else $error("digit lit in last slot cycle");
endmodule // vsc_slot_timer

//--- dv/vsc_dmem_model.sv
// Display data memory answering the controller's fetch port.
// Assumes the bench loads mem before display is enabled.
`timescale 1ns/1ps
module vsc_dmem_model (
  input wire logic clk, // main clock
  input wire logic dma_rd, // read request
  input wire logic [8:0] dma_addr, // nibble address
  output logic [3:0] dma_data // nibble, next cycle
);
  logic [3:0] mem [0:511];
  initial dma_data = 4'h0;
  // Idle cycles flip the nibble so stale data never passes
  always @(posedge clk) begin
    if (dma_rd) begin
      dma_data <= mem[dma_addr];
    end else begin
      dma_data <= ~dma_data;
    end
  end
endmodule // vsc_dmem_model

//--- dv/vfd_scan_controller_tb_top.sv
// Self-checking bench for the display scan controller.
// Assumes the design files and the memory model are compiled first.
`timescale 1ns/1ps
module vfd_scan_controller_tb_top;
  typedef struct packed {
    logic [15:0] dig;
    logic [23:0] seg;
  } vsc_note_t;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [11:0] cpu_addr = 12'h000;
  logic cpu_wr = 1'b0;
  logic cpu_rd = 1'b0;
  logic [7:0] cpu_wdata = 8'h00;
  logic [7:0] cpu_rdata;
  logic [8:0] dma_addr;
  logic dma_rd;
  logic [3:0] dma_data;
  logic [23:0] port_latch = 24'h000000;
  logic [23:0] segment_outputs;
  logic [15:0] digit_outputs;
  logic key_scan_irq;
  logic [7:0] rd_q [$];
  vsc_note_t pin_q [$];
  vsc_note_t e;
  int miscompares = 0;
  int n_compared = 0;
  int cyc = 0;
  int last0 = -1;
  int period = 0;
  int exp_lit = 0;
  int lit = 0;
  bit rd_seen = 1'b0;
  bit ks_pend = 1'b0;
  logic [15:0] prev_dig = 16'h0000;
  logic [31:0] seed = 32'd25524;

  always #50 clk = ~clk;

  vsc_scan_controller dut (.clk(clk), .rst(rst), .cpu_addr(cpu_addr), .cpu_wr(cpu_wr), .cpu_rd(cpu_rd),
    .cpu_wdata(cpu_wdata), .cpu_rdata(cpu_rdata), .dma_addr(dma_addr), .dma_rd(dma_rd), .dma_data(dma_data),
    .port_latch(port_latch), .segment_outputs(segment_outputs), .digit_outputs(digit_outputs),
    .key_scan_irq(key_scan_irq));
  vsc_dmem_model mdl (.clk(clk), .dma_rd(dma_rd), .dma_addr(dma_addr), .dma_data(dma_data));

  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction

  function automatic logic [23:0] seg_of(input int d, input int k);
    logic [23:0] s;
    for (int i = 0; i < 4; i++) s[4*i +: 4] = mdl.mem[9'h1C0 + 4*d + i];
    s[19:16] = mdl.mem[9'h1A0 + 2*d];
    s[23:20] = mdl.mem[9'h1A0 + 2*d + 1];
    for (int i = 9 + k; i < 16; i++) s[i] = 1'b0;
    return s;
  endfunction

  function automatic logic [23:0] ks_seg();
    return {mdl.mem[9'h1BF], mdl.mem[9'h1BE], mdl.mem[9'h1FF], mdl.mem[9'h1FE], mdl.mem[9'h1FD], mdl.mem[9'h1FC]};
  endfunction

  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic summarize;
    if (miscompares == 0 && n_compared > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    @(negedge clk);
    cpu_addr = a;
    cpu_wdata = d;
    cpu_wr = 1'b1;
    @(negedge clk);
    cpu_wr = 1'b0;
  endtask

  task automatic rd(input logic [11:0] a, input logic [7:0] x);
    @(negedge clk);
    cpu_addr = a;
    cpu_rd = 1'b1;
    rd_q.push_back(x);
    @(negedge clk);
    cpu_rd = 1'b0;
  endtask

  // One enabled run: notes for a full period plus the next digit 0, then disable
  task automatic run(input logic [3:0] dim, input int k, input int n, input int slot, input int lit_x);
    int p;
    wr(12'hF89, {4'h0, dim});
    wr(12'hF8A, 8'(n));
    for (int d = 0; d <= n; d++) pin_q.push_back({16'h0001 << d, seg_of(d, k)});
    pin_q.push_back({16'h0000, ks_seg()});
    pin_q.push_back({16'h0001, seg_of(0, k)});
    period = slot * (n + 2);
    exp_lit = lit_x;
    last0 = -1;
    lit = 0;
    wr(12'hF88, 8'(8 + k));
    for (p = 0; p < 4 && dma_rd !== 1'b1; p++) @(negedge clk);
    for (int d = 0; d < 6; d++) begin
      chk("dma_rd", dma_rd, 1'b1);
      chk("dma_addr", dma_addr, d < 4 ? 9'h1C0 + d : 9'h19C + d);
      @(negedge clk);
    end
    chk("dma_rd", dma_rd, 1'b0);
    for (p = 0; p < 2 * period && pin_q.size() != 0; p++) @(negedge clk);
    if (pin_q.size() != 0) begin
      chk("pin_queue", pin_q.size(), 0);
      summarize();
    end
    exp_lit = 0;
    wr(12'hF88, 8'h00);
    repeat (10) @(negedge clk);
    chk("digit_outputs", digit_outputs, 16'h0000);
    chk("segment_outputs", segment_outputs, 24'h000000);
    chk("dma_rd", dma_rd, 1'b0);
  endtask

  always @(posedge clk) begin
    cyc <= cyc + 1;
    rd_seen <= cpu_rd;
  end

  // Pin monitor: each slot start or key scan request takes the oldest note
  always @(negedge clk) begin
    if (rd_seen) chk("cpu_rdata", cpu_rdata, rd_q.pop_front());
    if (pin_q.size() != 0 && (ks_pend || (digit_outputs !== 16'h0000 && prev_dig === 16'h0000))) begin
      e = pin_q.pop_front();
      chk("digit_outputs", digit_outputs, e.dig);
      chk("segment_outputs", segment_outputs, e.seg);
    end
    if (digit_outputs[0] === 1'b1 && prev_dig[0] !== 1'b1) begin
      if (last0 >= 0) chk("period", cyc - last0, period);
      last0 = cyc;
    end
    if (digit_outputs !== 16'h0000) begin
      lit++;
    end else begin
      if (prev_dig !== 16'h0000 && exp_lit > 0) chk("digit_width", lit, exp_lit);
      lit = 0;
    end
    ks_pend = (key_scan_irq === 1'b1);
    prev_dig = digit_outputs;
  end

  initial begin
    for (int i = 0; i < 512; i++) begin
      seed = xs(seed);
      mdl.mem[i] = seed[3:0];
    end
    repeat (20) @(posedge clk);
    @(negedge clk);
    rst = 1'b0;
    rd(12'hF88, 8'h00);
    rd(12'hF89, 8'h00);
    rd(12'hF8A, 8'h08);
    rd(12'h123, 8'h00);
    wr(12'hF8A, 8'h03);
    rd(12'hF8A, 8'h08);
    wr(12'hF88, 8'h07);
    rd(12'hF88, 8'h07);
    wr(12'hF89, 8'h0B);
    rd(12'hF89, 8'h0B);
    wr(12'hFD6, 8'h0F);
    wr(12'hFD4, 8'h30);
    rd(12'hFD4, 8'h30);
    for (int i = 0; i < 4; i++) begin
      seed = xs(seed);
      port_latch = seed[23:0];
      repeat (2) @(negedge clk);
      chk("segment_outputs", segment_outputs, port_latch);
    end
    wr(12'hFD6, 8'h00);
    wr(12'hFD4, 8'h00);
    wr(12'hF88, 8'h00);
    run(4'h0, 0, 8, 1024, 960);
    run(4'h5, 7, 9, 2048, 1536);
    summarize();
  end
endmodule // vfd_scan_controller_tb_top
